// ===== rtl/fpia_pkg.sv
// constants and types shared by the flash pin interrupt aggregator
package fpia_pkg;

    // geometry
    localparam int NUM_PINS = 6;
    localparam int FLAGS_PER_PIN = 4;
    localparam int NUM_FLAGS = NUM_PINS * FLAGS_PER_PIN;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int EVT_W = 2;

    // pin order on the flash_pins bus
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_DATA0 = 2;
    localparam int PIN_DATA3 = 5;

    // flag position inside each pin's group of four
    localparam int LVL_LOW_BIT = 0;
    localparam int LVL_HIGH_BIT = 1;
    localparam int EDGE_LOW_BIT = 2;
    localparam int EDGE_HIGH_BIT = 3;

    typedef logic [NUM_FLAGS-1:0] fpia_flags_t;
    typedef logic [EVT_W-1:0] fpia_evt_t;

    // register byte offsets
    localparam logic [ADDR_W-1:0] RAW_OFS = 8'h30;
    localparam logic [ADDR_W-1:0] EN0_OFS = 8'h34;
    localparam logic [ADDR_W-1:0] FORCE0_OFS = 8'h38;
    localparam logic [ADDR_W-1:0] STAT0_OFS = 8'h3c;
    localparam logic [ADDR_W-1:0] EN1_OFS = 8'h40;
    localparam logic [ADDR_W-1:0] FORCE1_OFS = 8'h44;
    localparam logic [ADDR_W-1:0] STAT1_OFS = 8'h48;
    localparam logic [ADDR_W-1:0] EVT_STAT_OFS = 8'h60;
    localparam logic [ADDR_W-1:0] EVT_MASK_OFS = 8'h64;

    // event status bit positions
    localparam int EVT_CORE0_BIT = 0;
    localparam int EVT_CORE1_BIT = 1;

    // reset values
    localparam fpia_flags_t ENABLE_RST = 24'h000000;
    localparam fpia_flags_t FORCE_RST = 24'h000000;
    localparam fpia_evt_t EVT_RST = 2'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;

endpackage

// ===== rtl/fpia_raw_if.sv
// raw flag bundle between the flag unit and the register block
`timescale 1ns/10ps
interface fpia_raw_if;
    import fpia_pkg::*;
    fpia_flags_t flags;
    fpia_flags_t clr;
    logic clr_en;
    modport unit (output flags, input clr, input clr_en);
    modport ctrl (input flags, output clr, output clr_en);
endinterface

// ===== rtl/fpia_flag_unit.sv
// per-pin level and sticky edge flag generation
`timescale 1ns/10ps
module fpia_flag_unit
(
    // clock and reset
    input logic clk,
    input logic rstn,
    // pin levels
    input logic [fpia_pkg::NUM_PINS-1:0] pins,
    // flags out, clears in
    fpia_raw_if.unit rif
);
    import fpia_pkg::*;

    logic [NUM_PINS-1:0] prev;
    logic prev_ok;

    // no edge is seen before the first sampled level after reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev <= '0;
            prev_ok <= 1'b0;
        end
        else
        begin
            prev <= pins;
            prev_ok <= 1'b1;
        end
    end

    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_pin
        localparam int B = i * FLAGS_PER_PIN;
        // each pin owns its sticky pair, so no flop is written by two processes
        logic lo_q;
        logic hi_q;
        wire fall = prev_ok & prev[i] & ~pins[i];
        wire rise = prev_ok & ~prev[i] & pins[i];
        wire clr_lo = rif.clr_en & rif.clr[B+EDGE_LOW_BIT];
        wire clr_hi = rif.clr_en & rif.clr[B+EDGE_HIGH_BIT];
        // a new edge wins over a clear in the same cycle
        wire next_lo = fall | (lo_q & ~clr_lo);
        wire next_hi = rise | (hi_q & ~clr_hi);

        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                lo_q <= 1'b0;
                hi_q <= 1'b0;
            end
            else
            begin
                lo_q <= next_lo;
                hi_q <= next_hi;
            end
        end

        assign rif.flags[B+LVL_LOW_BIT] = ~pins[i];
        assign rif.flags[B+LVL_HIGH_BIT] = pins[i];
        assign rif.flags[B+EDGE_LOW_BIT] = lo_q;
        assign rif.flags[B+EDGE_HIGH_BIT] = hi_q;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_edge_rise_set: assert property (prev_ok && !prev[PIN_SCLK] && pins[PIN_SCLK]
        |=> rif.flags[EDGE_HIGH_BIT])
        else $error("rising pin edge did not set its flag");

    a_edge_flag_hold: assert property (rif.flags[EDGE_LOW_BIT]
        && !(rif.clr_en && rif.clr[EDGE_LOW_BIT]) |=> rif.flags[EDGE_LOW_BIT])
        else $error("edge flag dropped without a clear");

    a_edge_wc_clear: assert property (rif.clr_en && rif.clr[EDGE_HIGH_BIT]
        && !(prev_ok && !prev[PIN_SCLK] && pins[PIN_SCLK]) |=> !rif.flags[EDGE_HIGH_BIT])
        else $error("edge flag survived a clear");

endmodule // fpia_flag_unit

// ===== rtl/fpia_top.sv
// flash pin interrupt aggregator: apb registers, per-core masking and forcing
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
module fpia_top
(
    // clock and reset
    input logic clk,
    input logic rstn,
    // apb slave
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [fpia_pkg::ADDR_W-1:0] paddr,
    input logic [fpia_pkg::DATA_W-1:0] pwdata,
    input logic [3:0] pstrb,
    output logic [fpia_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash interface pins
    input logic [fpia_pkg::NUM_PINS-1:0] flash_pins,
    // interrupt lines
    output logic core0_irq,
    output logic core1_irq,
    output logic summary_irq
);
    import fpia_pkg::*;

    fpia_raw_if rif ();

    fpia_flag_unit i_fpia_flag_unit
    (
        .clk(clk),
        .rstn(rstn),
        .pins(flash_pins),
        .rif(rif)
    );

    fpia_flags_t core0_source_enable;
    fpia_flags_t core0_source_force;
    fpia_flags_t core1_source_enable;
    fpia_flags_t core1_source_force;
    fpia_evt_t evt_status;
    fpia_evt_t evt_mask;

    // bus phases
    wire setup_ph = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_acc = access_ph & pwrite;
    wire rd_setup = setup_ph & ~pwrite;
    wire rd_acc = access_ph & ~pwrite;

    // address decode
    wire hit_raw = (paddr == RAW_OFS);
    wire hit_en0 = (paddr == EN0_OFS);
    wire hit_f0 = (paddr == FORCE0_OFS);
    wire hit_st0 = (paddr == STAT0_OFS);
    wire hit_en1 = (paddr == EN1_OFS);
    wire hit_f1 = (paddr == FORCE1_OFS);
    wire hit_st1 = (paddr == STAT1_OFS);
    wire hit_evs = (paddr == EVT_STAT_OFS);
    wire hit_evm = (paddr == EVT_MASK_OFS);
    wire mapped = hit_raw | hit_en0 | hit_f0 | hit_st0 | hit_en1
        | hit_f1 | hit_st1 | hit_evs | hit_evm;

    // byte lanes
    wire [DATA_W-1:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [DATA_W-1:0] wbits = pwdata & wmask;
    wire fpia_flags_t wkeep = ~wmask[NUM_FLAGS-1:0];
    wire fpia_flags_t wnew = wbits[NUM_FLAGS-1:0];

    // raw edge flags are cleared by writing ones
    assign rif.clr = wnew;
    assign rif.clr_en = wr_acc & hit_raw;

    // masked and forced views per core
    wire fpia_flags_t core0_masked_status =
        (rif.flags & core0_source_enable) | core0_source_force;
    wire fpia_flags_t core1_masked_status =
        (rif.flags & core1_source_enable) | core1_source_force;
    wire any0 = |core0_masked_status;
    wire any1 = |core1_masked_status;

    // next values of the writable registers
    wire fpia_flags_t next_en0 = (wr_acc & hit_en0) ?
        ((core0_source_enable & wkeep) | wnew) : core0_source_enable;
    wire fpia_flags_t next_f0 = (wr_acc & hit_f0) ?
        ((core0_source_force & wkeep) | wnew) : core0_source_force;
    wire fpia_flags_t next_en1 = (wr_acc & hit_en1) ?
        ((core1_source_enable & wkeep) | wnew) : core1_source_enable;
    wire fpia_flags_t next_f1 = (wr_acc & hit_f1) ?
        ((core1_source_force & wkeep) | wnew) : core1_source_force;
    wire fpia_evt_t next_evm = (wr_acc & hit_evm & pstrb[0]) ?
        pwdata[EVT_W-1:0] : evt_mask;

    // a core line rising is an event; read clears only what the read returned
    wire fpia_evt_t evt_set = {any1 & ~core1_irq, any0 & ~core0_irq};
    wire fpia_evt_t evt_clr = (rd_acc & hit_evs) ? prdata[EVT_W-1:0] : EVT_RST;
    wire fpia_evt_t next_evs = evt_set | (evt_status & ~evt_clr);

    // read data mux, reserved bits zero
    wire [DATA_W-1:0] rd_val =
        hit_raw ? {8'h00, rif.flags} :
        hit_en0 ? {8'h00, core0_source_enable} :
        hit_f0 ? {8'h00, core0_source_force} :
        hit_st0 ? {8'h00, core0_masked_status} :
        hit_en1 ? {8'h00, core1_source_enable} :
        hit_f1 ? {8'h00, core1_source_force} :
        hit_st1 ? {8'h00, core1_masked_status} :
        hit_evs ? {30'h0, evt_status} :
        hit_evm ? {30'h0, evt_mask} :
        RDATA_RST;

    // zero wait states; unmapped accesses report an error
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;

    // core zero enable mask
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core0_source_enable <= ENABLE_RST;
        end
        else
        begin
            core0_source_enable <= next_en0;
        end
    end

    // core zero force
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core0_source_force <= FORCE_RST;
        end
        else
        begin
            core0_source_force <= next_f0;
        end
    end

    // core one enable mask
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core1_source_enable <= ENABLE_RST;
        end
        else
        begin
            core1_source_enable <= next_en1;
        end
    end

    // core one force
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core1_source_force <= FORCE_RST;
        end
        else
        begin
            core1_source_force <= next_f1;
        end
    end

    // event status: a new rise wins over a read clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            evt_status <= EVT_RST;
        end
        else
        begin
            evt_status <= next_evs;
        end
    end

    // event mask
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            evt_mask <= EVT_RST;
        end
        else
        begin
            evt_mask <= next_evm;
        end
    end

    // read data is captured in the setup cycle and held through access
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prdata <= RDATA_RST;
        end
        else if (rd_setup)
        begin
            prdata <= rd_val;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core0_irq <= 1'b0;
            core1_irq <= 1'b0;
            summary_irq <= 1'b0;
        end
        else
        begin
            core0_irq <= any0;
            core1_irq <= any1;
            summary_irq <= |(next_evs & next_evm);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_raw_read_map: assert property (rd_acc && hit_raw
        |-> prdata[DATA_W-1:NUM_FLAGS] == 8'h00
        && prdata[NUM_FLAGS-1:0] == $past(rif.flags))
        else $error("raw register read wrong or reserved bits set");

    a_raw_level_pins: assert property (
        rif.flags[FLAGS_PER_PIN*PIN_CS+LVL_HIGH_BIT] == flash_pins[PIN_CS]
        && rif.flags[FLAGS_PER_PIN*PIN_DATA3+LVL_LOW_BIT] == !flash_pins[PIN_DATA3])
        else $error("level flag does not follow its pin");

    a_en0_write: assert property (wr_acc && hit_en0 && pstrb == 4'hf
        |=> core0_source_enable == $past(pwdata[NUM_FLAGS-1:0]))
        else $error("core zero enable write lost");

    a_force0_line: assert property (core0_source_force != ENABLE_RST
        |=> core0_irq)
        else $error("core zero force did not raise the line");

    a_stat0_read: assert property (rd_acc && hit_st0
        |-> prdata[NUM_FLAGS-1:0] == (($past(rif.flags) & $past(core0_source_enable))
        | $past(core0_source_force)))
        else $error("core zero status read wrong");

    a_en1_write: assert property (wr_acc && hit_en1 && pstrb == 4'hf
        |=> core1_source_enable == $past(pwdata[NUM_FLAGS-1:0])
        && core0_source_enable == $past(core0_source_enable))
        else $error("core one enable write wrong or leaked");

    a_force1_line: assert property (core1_source_force != FORCE_RST
        |=> core1_irq)
        else $error("core one force did not raise the line");

    a_stat1_read: assert property (rd_acc && hit_st1
        |-> prdata[NUM_FLAGS-1:0] == (($past(rif.flags) & $past(core1_source_enable))
        | $past(core1_source_force)))
        else $error("core one status read wrong");

    a_core_line_or: assert property (core0_masked_status == ENABLE_RST
        |=> !core0_irq)
        else $error("core zero line high with empty status");

    a_evt_sticky: assert property ($rose(core0_irq) |-> evt_status[EVT_CORE0_BIT])
        else $error("core zero rise not recorded");

    a_unmapped_err: assert property (access_ph && !mapped |-> pslverr)
        else $error("unmapped access not refused");

    a_unmapped_rd: assert property (rd_acc && !mapped |-> prdata == RDATA_RST)
        else $error("unmapped read returned data");

    a_unmapped_wr: assert property (wr_acc && !mapped
        |=> core0_source_enable == $past(core0_source_enable)
        && core1_source_force == $past(core1_source_force))
        else $error("unmapped write changed a register");

    a_en0_read: assert property (rd_acc && hit_en0
        |-> prdata == {8'h00, $past(core0_source_enable)})
        else $error("core zero enable read wrong");

    a_force0_write: assert property (wr_acc && hit_f0 && pstrb == 4'hf
        |=> core0_source_force == $past(pwdata[NUM_FLAGS-1:0]))
        else $error("core zero force write lost");

    a_force0_read: assert property (rd_acc && hit_f0
        |-> prdata == {8'h00, $past(core0_source_force)})
        else $error("core zero force read wrong");

    a_en1_read: assert property (rd_acc && hit_en1
        |-> prdata == {8'h00, $past(core1_source_enable)})
        else $error("core one enable read wrong");

    a_force1_write: assert property (wr_acc && hit_f1 && pstrb == 4'hf
        |=> core1_source_force == $past(pwdata[NUM_FLAGS-1:0])
        && core0_source_force == $past(core0_source_force))
        else $error("core one force write wrong or leaked");

    a_force1_read: assert property (rd_acc && hit_f1
        |-> prdata == {8'h00, $past(core1_source_force)})
        else $error("core one force read wrong");

    a_status_ro: assert property (wr_acc && (hit_st0 || hit_st1)
        |=> core0_source_enable == $past(core0_source_enable)
        && core0_source_force == $past(core0_source_force)
        && core1_source_enable == $past(core1_source_enable)
        && core1_source_force == $past(core1_source_force))
        else $error("status write changed a register");

    a_core0_line_set: assert property (core0_masked_status != ENABLE_RST
        |=> core0_irq)
        else $error("core zero line low with pending status");

    a_core1_line_or: assert property (core1_masked_status == ENABLE_RST
        |=> !core1_irq)
        else $error("core one line high with empty status");

    a_evt1_sticky: assert property ($rose(core1_irq) |-> evt_status[EVT_CORE1_BIT])
        else $error("core one rise not recorded");

    a_evt_read_clr: assert property (rd_acc && hit_evs && prdata[EVT_CORE0_BIT]
        && !(any0 && !core0_irq) |=> !evt_status[EVT_CORE0_BIT])
        else $error("event read did not clear its bit");

    a_summary_level: assert property (summary_irq == |(evt_status & evt_mask))
        else $error("summary line disagrees with masked events");

    c_edge_read: cover property (rd_acc && hit_raw && prdata[EDGE_HIGH_BIT]);
    c_force_irq: cover property (core1_source_force != FORCE_RST ##1 core1_irq);
    c_evt_clear: cover property (rd_acc && hit_evs && prdata[EVT_CORE0_BIT]);
    c_summary: cover property ($rose(summary_irq));
    c_core1_rise: cover property ($rose(core1_irq));

endmodule // fpia_top

// ===== tb/fpia_core_sink.sv
// model of the two cores: counts each rise of its interrupt line
`timescale 1ns/10ps
module fpia_core_sink
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // interrupt lines from the block
    input wire logic irq0,
    input wire logic irq1,
    // rises taken by each core
    output logic [7:0] taken0,
    output logic [7:0] taken1
);
    logic last0;
    logic last1;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            last0 <= 1'b0;
            last1 <= 1'b0;
            taken0 <= 8'h00;
            taken1 <= 8'h00;
        end
        else
        begin
            last0 <= irq0;
            last1 <= irq1;
            taken0 <= taken0 + 8'(irq0 & !last0);
            taken1 <= taken1 + 8'(irq1 & !last1);
        end
    end
endmodule // fpia_core_sink

// ===== tb/tb_fpia.sv
// self-checking bench of the flash pin interrupt aggregator
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_fpia;
    import fpia_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h00000000, prdata, q;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, core0_irq, core1_irq, summary_irq, e;
    logic [NUM_PINS-1:0] flash_pins = 6'h00;
    logic [7:0] taken0, taken1;
    int n_fail = 0, checks = 0;
    fpia_top i_fpia_top (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_pins(flash_pins),
        .core0_irq(core0_irq), .core1_irq(core1_irq), .summary_irq(summary_irq));
    fpia_core_sink i_fpia_core_sink (.clk(clk), .rstn(rstn), .irq0(core0_irq),
        .irq1(core1_irq), .taken0(taken0), .taken1(taken1));
    initial forever #10 clk = ~clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 16)
            begin
                n_fail++;
                close_out();
            end
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h00000000);
        `CHK(q, x)
    endtask
    task automatic t_reset();
        rd(EN0_OFS, 32'h0);
        rd(FORCE0_OFS, 32'h0);
        rd(EN1_OFS, 32'h0);
        rd(FORCE1_OFS, 32'h0);
        rd(STAT0_OFS, 32'h0);
        rd(RAW_OFS, 32'h00111111);
        $display("test reset done");
    endtask
    task automatic t_edges();
        flash_pins <= 6'h3f;
        repeat (3) @(posedge clk);
        rd(RAW_OFS, 32'h00aaaaaa);
        flash_pins <= 6'h00;
        repeat (3) @(posedge clk);
        rd(RAW_OFS, 32'h00dddddd);
        xfer(1'b1, RAW_OFS, 32'hffffffff);
        rd(RAW_OFS, 32'h00111111);
        $display("test edges done");
    endtask
    task automatic t_core0();
        xfer(1'b1, EVT_MASK_OFS, 32'h3);
        xfer(1'b1, EN0_OFS, 32'hff000001);
        rd(EN0_OFS, 32'h00000001);
        rd(STAT0_OFS, 32'h00000001);
        `CHK({core0_irq, core1_irq, summary_irq}, 3'b101)
        rd(EVT_STAT_OFS, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(summary_irq, 1'b0)
        xfer(1'b1, EN0_OFS, 32'h0);
        xfer(1'b1, FORCE0_OFS, 32'h00800000);
        rd(STAT0_OFS, 32'h00800000);
        `CHK({core0_irq, summary_irq}, 2'b11)
        xfer(1'b1, EVT_MASK_OFS, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(summary_irq, 1'b0)
        rd(EVT_STAT_OFS, 32'h1);
        xfer(1'b1, FORCE0_OFS, 32'h0);
        rd(STAT0_OFS, 32'h0);
        `CHK({core0_irq, taken0}, {1'b0, 8'h02})
        $display("test core0 done");
    endtask
    task automatic t_core1();
        xfer(1'b1, EN1_OFS, 32'h00000010);
        xfer(1'b1, FORCE1_OFS, 32'h00000100);
        rd(STAT1_OFS, 32'h00000110);
        rd(STAT0_OFS, 32'h0);
        rd(EN0_OFS, 32'h0);
        rd(FORCE0_OFS, 32'h0);
        `CHK({core0_irq, core1_irq}, 2'b01)
        xfer(1'b1, EN1_OFS, 32'h0);
        rd(STAT1_OFS, 32'h00000100);
        xfer(1'b1, FORCE1_OFS, 32'h0);
        rd(STAT1_OFS, 32'h0);
        `CHK({core1_irq, taken1}, {1'b0, 8'h01})
        $display("test core1 done");
    endtask
    task automatic t_errors();
        rd(8'h70, 32'h0);
        `CHK(e, 1'b1)
        rd(8'h31, 32'h0);
        `CHK(e, 1'b1)
        xfer(1'b1, 8'h70, 32'hffffffff);
        `CHK(e, 1'b1)
        xfer(1'b1, STAT0_OFS, 32'hffffffff);
        rd(STAT0_OFS, 32'h0);
        `CHK(e, 1'b0)
        $display("test errors done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_edges();
        t_core0();
        t_core1();
        t_errors();
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end
endmodule // tb_fpia
